// *** rtl/tsrb_pkg.sv ***
// Purpose: Shared constants and types of the temperature register bank.
// Assumes: Results arrive as signed fixed point with FRAC_W fraction bits.
// Notes: Result and setpoint register values are signed whole degrees Celsius.
package tsrb_pkg;
    localparam int RAW_W = 11;
    localparam int FRAC_W = 2;
    localparam int WHOLE_W = RAW_W + 1 - FRAC_W;

    // Command codes of the register port.
    localparam logic [7:0] CMD_RD_INNER_TEMP = 8'h00;
    localparam logic [7:0] CMD_RD_REMOTE_TEMP = 8'h01;
    localparam logic [7:0] CMD_RD_STATUS = 8'h02;
    localparam logic [7:0] CMD_RD_INNER_UPPER = 8'h05;
    localparam logic [7:0] CMD_RD_INNER_LOWER = 8'h06;
    localparam logic [7:0] CMD_RD_REMOTE_UPPER = 8'h07;
    localparam logic [7:0] CMD_RD_REMOTE_LOWER = 8'h08;
    localparam logic [7:0] CMD_WR_INNER_UPPER = 8'h0B;
    localparam logic [7:0] CMD_WR_INNER_LOWER = 8'h0C;
    localparam logic [7:0] CMD_WR_REMOTE_UPPER = 8'h0D;
    localparam logic [7:0] CMD_WR_REMOTE_LOWER = 8'h0E;

    // Reset values and fixed codes.
    localparam logic [7:0] TEMP_RST = 8'h00;
    localparam logic [7:0] UPPER_RST = 8'h7F;
    localparam logic [7:0] LOWER_RST = 8'hC9;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ERR_DATA = 8'hFF;
    localparam logic [7:0] TEMP_MAX = 8'h7F;
    localparam logic [7:0] TEMP_MIN = 8'h80;
    localparam logic [1:0] STATUS_RSV = 2'h0;
    localparam logic signed [WHOLE_W-1:0] WHOLE_MAX = WHOLE_W'(127);
    localparam logic signed [WHOLE_W-1:0] WHOLE_MIN = -WHOLE_W'(128);
    localparam logic [RAW_W:0] ROUND_HALF = (RAW_W+1)'(2 ** (FRAC_W - 1));

    // Positions inside the five latched flags.
    localparam int FLAG_INNER_UPPER = 4;
    localparam int FLAG_INNER_LOWER = 3;
    localparam int FLAG_REMOTE_UPPER = 2;
    localparam int FLAG_REMOTE_LOWER = 1;
    localparam int FLAG_DIODE_FAULT = 0;

    typedef enum logic {
        CH_INNER,
        CH_REMOTE
    } tsrb_chan_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] cmd;
        logic [7:0] wdata;
    } tsrb_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic diode_open;
        logic signed [RAW_W-1:0] raw;
    } tsrb_conv_t;

    typedef struct packed {
        logic [7:0] inner_temp_result;
        logic [7:0] remote_temp_result;
        logic [7:0] inner_upper_setpoint;
        logic [7:0] inner_lower_setpoint;
        logic [7:0] remote_upper_setpoint;
        logic [7:0] remote_lower_setpoint;
        logic [4:0] flags;
        tsrb_chan_t chan;
        logic [7:0] rdata;
        logic rvalid;
    } tsrb_state_t;
endpackage

// *** rtl/tsrb_regs.sv ***
// Purpose: Result, setpoint and status registers of a two-channel monitor.
// Assumes: The serial engine issues one-cycle read and write strobes.
// Notes: The converter delivers one channel per done pulse, as CHANNEL says.
`timescale 1ns/1ps

// Contract
// - Hold latest inner and remote results in two read-only signed bytes.
// - Results update alternately, one channel per conversion.
// - One count is one degree; code zero is zero degrees.
// - Round to nearest degree, half ties toward positive.
// - Clamp above range to 7F; negatives down to 80 stay representable, lower ones clamp to 80.
// - Four signed setpoints: upper and lower per channel.
// - Inner setpoints compare to inner result, remote to remote only.
// - Setpoint writes are accepted at any moment, even mid-conversion.
// - Upper setpoints reset to 7F, lower setpoints reset to C9.
// - Status bit 7 shows live converter busy from CONV_IN; reset does not clear it.
// - Status bits 6..3 latch the four limit events; zero at reset.
// - Status bit 2 flags remote diode fault; bits 1..0 read zero.
// - Completing a status read clears flag bits 6..2, except ones set by a result in the same cycle.
// - Open remote diode makes the remote result read 7F.
module tsrb_regs (
    input wire logic CLK,
    input wire logic RESETN,
    input wire tsrb_pkg::tsrb_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire tsrb_pkg::tsrb_conv_t CONV_IN,
    output logic CONV_CHANNEL
);
    tsrb_pkg::tsrb_state_t state_r;
    tsrb_pkg::tsrb_state_t state_nxt;
    logic [7:0] status_byte;
    logic [7:0] new_code;
    logic [4:0] flag_set;
    logic flag_clr;

    // Fixed point to whole degrees. Adding one half before the floor
    // shift sends exact ties upward, so -0.5 becomes 0 and +0.5 becomes 1.
    function automatic logic [7:0] round_clamp(
        input logic signed [tsrb_pkg::RAW_W-1:0] raw
    );
        logic [tsrb_pkg::RAW_W:0] sum;
        logic signed [tsrb_pkg::WHOLE_W-1:0] whole;
        logic [7:0] code;
        sum = {raw[tsrb_pkg::RAW_W-1], raw} + tsrb_pkg::ROUND_HALF;
        whole = $signed(sum[tsrb_pkg::RAW_W:tsrb_pkg::FRAC_W]);
        if (whole > tsrb_pkg::WHOLE_MAX) begin
            code = tsrb_pkg::TEMP_MAX;
        end else if (whole < tsrb_pkg::WHOLE_MIN) begin
            code = tsrb_pkg::TEMP_MIN;
        end else begin
            code = whole[7:0];
        end
        return code;
    endfunction

    // Busy is live converter state, not a latched event.
    assign status_byte = {CONV_IN.busy, state_r.flags,
                          tsrb_pkg::STATUS_RSV};

    always_comb begin
        state_nxt = state_r;
        state_nxt.rvalid = 1'b0;
        flag_set = '0;
        flag_clr = 1'b0;
        new_code = tsrb_pkg::TEMP_RST;

        // Setpoint writes have no guard against a running conversion.
        if (REG_REQ.wr) begin
            case (REG_REQ.cmd)
                tsrb_pkg::CMD_WR_INNER_UPPER: begin
                    state_nxt.inner_upper_setpoint = REG_REQ.wdata;
                end
                tsrb_pkg::CMD_WR_INNER_LOWER: begin
                    state_nxt.inner_lower_setpoint = REG_REQ.wdata;
                end
                tsrb_pkg::CMD_WR_REMOTE_UPPER: begin
                    state_nxt.remote_upper_setpoint = REG_REQ.wdata;
                end
                tsrb_pkg::CMD_WR_REMOTE_LOWER: begin
                    state_nxt.remote_lower_setpoint = REG_REQ.wdata;
                end
                default: begin
                end
            endcase
        end

        if (REG_REQ.rd) begin
            state_nxt.rvalid = 1'b1;
            case (REG_REQ.cmd)
                tsrb_pkg::CMD_RD_INNER_TEMP: begin
                    state_nxt.rdata = state_r.inner_temp_result;
                end
                tsrb_pkg::CMD_RD_REMOTE_TEMP: begin
                    state_nxt.rdata = state_r.remote_temp_result;
                end
                tsrb_pkg::CMD_RD_STATUS: begin
                    state_nxt.rdata = status_byte;
                    flag_clr = 1'b1;
                end
                tsrb_pkg::CMD_RD_INNER_UPPER: begin
                    state_nxt.rdata = state_r.inner_upper_setpoint;
                end
                tsrb_pkg::CMD_RD_INNER_LOWER: begin
                    state_nxt.rdata = state_r.inner_lower_setpoint;
                end
                tsrb_pkg::CMD_RD_REMOTE_UPPER: begin
                    state_nxt.rdata = state_r.remote_upper_setpoint;
                end
                tsrb_pkg::CMD_RD_REMOTE_LOWER: begin
                    state_nxt.rdata = state_r.remote_lower_setpoint;
                end
                default: begin
                    // Codes outside this bank answer with the error byte.
                    state_nxt.rdata = tsrb_pkg::ERR_DATA;
                end
            endcase
        end

        if (CONV_IN.done) begin
            // Compare against setpoints as they stood before this cycle;
            // a write in the same cycle counts from the next result on.
            case (state_r.chan)
                tsrb_pkg::CH_INNER: begin
                    new_code = round_clamp(CONV_IN.raw);
                    state_nxt.inner_temp_result = new_code;
                    flag_set[tsrb_pkg::FLAG_INNER_UPPER] =
                        $signed(new_code) >
                        $signed(state_r.inner_upper_setpoint);
                    flag_set[tsrb_pkg::FLAG_INNER_LOWER] =
                        $signed(new_code) <
                        $signed(state_r.inner_lower_setpoint);
                    state_nxt.chan = tsrb_pkg::CH_REMOTE;
                end
                tsrb_pkg::CH_REMOTE: begin
                    if (CONV_IN.diode_open) begin
                        new_code = tsrb_pkg::TEMP_MAX;
                    end else begin
                        new_code = round_clamp(CONV_IN.raw);
                    end
                    state_nxt.remote_temp_result = new_code;
                    flag_set[tsrb_pkg::FLAG_REMOTE_UPPER] =
                        $signed(new_code) >
                        $signed(state_r.remote_upper_setpoint);
                    flag_set[tsrb_pkg::FLAG_REMOTE_LOWER] =
                        $signed(new_code) <
                        $signed(state_r.remote_lower_setpoint);
                    flag_set[tsrb_pkg::FLAG_DIODE_FAULT] =
                        CONV_IN.diode_open;
                    state_nxt.chan = tsrb_pkg::CH_INNER;
                end
                default: begin
                    state_nxt.chan = tsrb_pkg::CH_INNER;
                end
            endcase
        end

        // A new event in the clearing cycle survives the clear.
        state_nxt.flags = (state_r.flags & ~{5{flag_clr}})
                          | flag_set;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_r.inner_temp_result <= tsrb_pkg::TEMP_RST;
            state_r.remote_temp_result <= tsrb_pkg::TEMP_RST;
            state_r.inner_upper_setpoint <= tsrb_pkg::UPPER_RST;
            state_r.inner_lower_setpoint <= tsrb_pkg::LOWER_RST;
            state_r.remote_upper_setpoint <= tsrb_pkg::UPPER_RST;
            state_r.remote_lower_setpoint <= tsrb_pkg::LOWER_RST;
            state_r.flags <= tsrb_pkg::FLAGS_RST;
            state_r.chan <= tsrb_pkg::CH_INNER;
            state_r.rdata <= tsrb_pkg::DATA_RST;
            state_r.rvalid <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign REG_RDATA = state_r.rdata;
    assign REG_RVALID = state_r.rvalid;
    assign CONV_CHANNEL = (state_r.chan == tsrb_pkg::CH_REMOTE);
endmodule

// *** verif/tsrb_regs_checker.sv ***
// Purpose: Port assertions of the temperature register bank.
// Assumes: Only the top module's ports are seen.
// Notes: Every check is off while RESETN is low.
`timescale 1ns/1ps
module tsrb_regs_checker (
    input wire logic CLK,
    input wire logic RESETN,
    input wire tsrb_pkg::tsrb_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire tsrb_pkg::tsrb_conv_t CONV_IN,
    input wire logic CONV_CHANNEL
);
    logic st_rd;
    assign st_rd = REG_REQ.rd && REG_REQ.cmd == tsrb_pkg::CMD_RD_STATUS;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    a_read_answered: assert property (
        REG_REQ.rd |=> REG_RVALID) else $error("read not answered");
    a_no_stray_valid: assert property (
        !REG_REQ.rd |=> !REG_RVALID) else $error("stray read valid");
    a_reserved_zero: assert property (
        st_rd |=> REG_RDATA[1:0] == tsrb_pkg::STATUS_RSV)
        else $error("reserved status bits set");
    a_busy_shown: assert property (
        st_rd |=> REG_RDATA[7] == $past(CONV_IN.busy))
        else $error("busy bit wrong");
    a_chan_toggles: assert property (
        CONV_IN.done |=> CONV_CHANNEL != $past(CONV_CHANNEL))
        else $error("channel did not alternate");
    a_chan_steady: assert property (
        !CONV_IN.done |=> $stable(CONV_CHANNEL))
        else $error("channel moved without a result");
    a_status_cleared: assert property (
        (st_rd && !CONV_IN.done) ##1 !CONV_IN.done ##1 st_rd
        |=> REG_RDATA[6:2] == 5'h00)
        else $error("flags survived a status read");
    a_open_diode_max: assert property (
        (CONV_IN.done && CONV_CHANNEL && CONV_IN.diode_open) ##[1:2]
        (REG_REQ.rd && REG_REQ.cmd == tsrb_pkg::CMD_RD_REMOTE_TEMP)
        |=> REG_RDATA == tsrb_pkg::TEMP_MAX) else $error("open diode code");
endmodule
bind tsrb_regs tsrb_regs_checker tsrb_regs_checker_inst (.CLK(CLK),
    .RESETN(RESETN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .CONV_IN(CONV_IN), .CONV_CHANNEL(CONV_CHANNEL));

// *** verif/tsrb_host_model.sv ***
// Purpose: Host controller model issuing register reads and writes.
// Assumes: Strobes last one cycle and change at the falling edge.
// Notes: Idle lines carry inverted values so stale data is never reused.
`timescale 1ns/1ps
module tsrb_host_model (
    input wire logic CLK,
    output tsrb_pkg::tsrb_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID
);
    initial REG_REQ = '0;
    task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
        @(negedge CLK);
        REG_REQ = '{1'b0, 1'b1, cmd, v};
        @(negedge CLK);
        REG_REQ = '{1'b0, 1'b0, ~cmd, ~v};
    endtask
    task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
        @(negedge CLK);
        REG_REQ = '{1'b1, 1'b0, cmd, 8'hA5};
        @(negedge CLK);
        REG_REQ = '{1'b0, 1'b0, ~cmd, 8'h5A};
        v = (REG_RVALID === 1'b1) ? REG_RDATA : 8'hXX;
    endtask
endmodule

// *** verif/tb_top.sv ***
// Purpose: Directed register and conversion tests of the register bank.
// Assumes: Converter strobes are driven at the falling edge.
// Notes: Raw inputs are quarter degrees; expected codes are hand rounded.
`timescale 1ns/1ps
module tb_top;
    logic CLK, RESETN, REG_RVALID, CONV_CHANNEL;
    logic [7:0] REG_RDATA, d;
    tsrb_pkg::tsrb_req_t REG_REQ;
    tsrb_pkg::tsrb_conv_t CONV_IN;
    int mismatches = 0, n_checks = 0, cycles = 0;
    logic [7:0] cm[7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h00, 8'h01, 8'h02};
    logic [7:0] rv[7] = '{8'h7F, 8'hC9, 8'h7F, 8'hC9, 8'h00, 8'h00, 8'h00};
    logic [7:0] lm[4] = '{8'h19, 8'hE7, 8'h05, 8'hFB};
    logic [10:0] rw[7] = '{11'h002, 11'h001, 11'h7FE, 11'h7FD, 11'h208,
        11'h6FC, 11'h065};
    logic [7:0] cd[7] = '{8'h01, 8'h00, 8'h00, 8'hFF, 8'h7F, 8'hBF, 8'h19};
    tsrb_regs tsrb_regs_inst (.CLK(CLK), .RESETN(RESETN), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CONV_IN(CONV_IN),
        .CONV_CHANNEL(CONV_CHANNEL));
    tsrb_host_model tsrb_host_model_inst (.CLK(CLK), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] cmd, input logic [7:0] exp);
        tsrb_host_model_inst.rd(cmd, d);
        check(d, exp);
    endtask
    task automatic conv(input logic [10:0] raw, input logic op);
        @(negedge CLK);
        CONV_IN.done = 1'b1;
        CONV_IN.raw = raw;
        CONV_IN.diode_open = op;
        @(negedge CLK);
        CONV_IN.done = 1'b0;
        CONV_IN.diode_open = 1'b0;
    endtask
    task automatic pair(input logic [10:0] ri, rr, input logic op);
        check({7'h00, CONV_CHANNEL}, 8'h00);
        conv(ri, 1'b0);
        check({7'h00, CONV_CHANNEL}, 8'h01);
        conv(rr, op);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // The whole sequence needs well under a thousand cycles.
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        RESETN = 1'b0;
        CONV_IN = '0;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        RESETN = 1'b1;
        for (int i = 0; i < 7; i++) rdc(cm[i], rv[i]);
        $display("reset test done");
        CONV_IN.busy = 1'b1;
        for (int i = 0; i < 4; i++) begin
            tsrb_host_model_inst.wr(8'(cm[i] + 8'h06), lm[i]);
        end
        for (int i = 0; i < 4; i++) rdc(cm[i], lm[i]);
        rdc(8'h02, 8'h80);
        CONV_IN.busy = 1'b0;
        $display("setpoint test done");
        for (int i = 0; i < 7; i++) begin
            pair(rw[i], rw[i], 1'b0);
            rdc(8'h00, cd[i]);
            rdc(8'h01, cd[i]);
        end
        tsrb_host_model_inst.rd(8'h02, d);
        $display("rounding test done");
        pair(11'h064, 11'h014, 1'b0);
        rdc(8'h02, 8'h00);
        pair(11'h068, 11'h000, 1'b0);
        rdc(8'h02, 8'h40);
        rdc(8'h02, 8'h00);
        pair(11'h798, 11'h7E8, 1'b0);
        pair(11'h000, 11'h000, 1'b0);
        rdc(8'h02, 8'h28);
        pair(11'h000, 11'h000, 1'b1);
        rdc(8'h01, 8'h7F);
        rdc(8'h02, 8'h14);
        $display("event test done");
        complete_run();
    end
endmodule
